// [include/port_cmd_pkg.sv]
/*
  Shared constants and types of the port command block: register byte offsets, field
  positions, reset values, port commands and function codes.
  Assumes a 32-bit Avalon-MM register slave with byte addresses and 16-bit registers.
*/
package port_cmd_pkg;
  localparam int          BUS_W          = 32;
  localparam int          REG_W          = 16;
  localparam int          BASE_W         = 18;
  localparam int          BLOCK_WORDS    = 4;
  localparam logic [4:0]  OFS_CMD_STATUS = 5'h00;
  localparam logic [4:0]  OFS_BASE_LOW   = 5'h08;
  localparam logic [4:0]  OFS_BASE_HIGH  = 5'h0c;
  localparam logic [4:0]  OFS_PORT_STATE = 5'h10;
  localparam int          CMD_LSB        = 0;
  localparam int          CMD_W          = 4;
  localparam int          RESET_BIT      = 5;
  localparam int          IE_BIT         = 6;
  localparam int          SUMMARY_BIT    = 7;
  localparam int          FLAG_LSB       = 8;
  localparam int          DONE_BIT       = 13;
  localparam int          ERROR_BIT      = 14;
  localparam int          RUNNING_BIT    = 15;
  localparam logic [3:0]  CMD_NULL       = 4'h0;
  localparam logic [3:0]  CMD_LATCH_BASE = 4'h1;
  localparam logic [3:0]  CMD_FETCH      = 4'h2;
  localparam logic [15:0] BASE_LOW_RESET = 16'h0000;
  localparam logic [1:0]  BASE_HIGH_RESET = 2'h0;
  localparam logic [7:0]  FC_NULL        = 8'h00;
  localparam logic [7:0]  FC_START_UCODE = 8'h01;
  localparam logic [7:0]  FC_NULL_ALT    = 8'h03;
  localparam logic [7:0]  FC_NET_FIRST   = 8'h02;
  localparam logic [7:0]  FC_NET_LAST    = 8'h0f;
  localparam logic [7:0]  FC_MAINT_FIRST = 8'h10;
  localparam logic [7:0]  FC_MAINT_LAST  = 8'h15;
  localparam logic [17:0] WORD_STEP      = 18'h00002;
  typedef enum logic [2:0] {
    FN_NULL, FN_START_UCODE, FN_NETWORK, FN_MAINT, FN_ILLEGAL
  } func_class_type;
endpackage : port_cmd_pkg

// [src/block_fetcher.sv]
/*
  Reads the four-word control block from host memory over an Avalon-MM read master.
  Assumes memory holds mem_read asserted requests until waitrequest is low.
*/
`timescale 1ns/1ps
module block_fetcher
  import port_cmd_pkg::*;
#(
  parameter int WORDS = port_cmd_pkg::BLOCK_WORDS
)(
  input  wire logic                             ref_clk,
  input  wire logic                             rst_b,
  input  wire logic                             abort,
  input  wire logic                             start,
  input  wire logic [port_cmd_pkg::BASE_W-1:0]  base,
  output logic                                  mem_read,
  output logic [port_cmd_pkg::BASE_W-1:0]       mem_address,
  input  wire logic [port_cmd_pkg::REG_W-1:0]   mem_readdata,
  input  wire logic                             mem_waitrequest,
  output logic [port_cmd_pkg::REG_W-1:0]        words [WORDS],
  output logic                                  done
);
  // the word index is two bits wide, so only a four-word block can be served
  if (WORDS != BLOCK_WORDS)
  begin : g_words_check
    $error("block_fetcher serves four words only");
  end
  logic [1:0]                 index;
  logic [1:0]                 next_index;
  logic                       next_read;
  logic                       next_done;
  logic [BASE_W-1:0]          next_address;
  logic [REG_W-1:0]           next_words [WORDS];
  always_comb
  begin
    next_index   = index;
    next_read    = mem_read;
    next_done    = 1'b0;
    next_address = mem_address;
    next_words   = words;
    if (abort)
    begin
      next_read = 1'b0;
    end
    else if (!mem_read && start)
    begin
      next_read    = 1'b1;
      next_index   = 2'd0;
      next_address = base;
    end
    else if (mem_read && !mem_waitrequest)
    begin
      next_words[index] = mem_readdata;
      next_index        = index + 2'd1;
      next_address      = mem_address + WORD_STEP;
      if (index == 2'(WORDS - 1))
      begin
        next_read = 1'b0;
        next_done = 1'b1;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      index       <= 2'd0;
      mem_read    <= 1'b0;
      done        <= 1'b0;
      mem_address <= '0;
      words       <= '{default: '0};
    end
    else
    begin
      index       <= next_index;
      mem_read    <= next_read;
      done        <= next_done;
      mem_address <= next_address;
      words       <= next_words;
    end
  end
endmodule : block_fetcher

// [src/function_decoder.sv]
/*
  Classifies a fetched control block and checks the start-microcode operands.
  Assumes the words stay stable while the result is sampled.
*/
`timescale 1ns/1ps
module function_decoder
  import port_cmd_pkg::*;
(
  input  wire logic [port_cmd_pkg::REG_W-1:0] word0,
  input  wire logic [port_cmd_pkg::REG_W-1:0] word1,
  input  wire logic                           running,
  output port_cmd_pkg::func_class_type        func_class,
  output logic                                func_ok,
  output logic                                start_ucode
);
  logic [7:0] code;
  always_comb
  begin
    code = word0[7:0];
    if (code == FC_NULL || code == FC_NULL_ALT)
      func_class = FN_NULL;
    else if (code == FC_START_UCODE)
      func_class = FN_START_UCODE;
    else if (code >= FC_NET_FIRST && code <= FC_NET_LAST)
      func_class = FN_NETWORK;
    else if (code >= FC_MAINT_FIRST && code <= FC_MAINT_LAST)
      func_class = FN_MAINT;
    else
      func_class = FN_ILLEGAL;
    // network and maintenance functions are decoded but not carried out by this block
    case (func_class)
      FN_NULL:        func_ok = 1'b1;
      FN_START_UCODE: func_ok = (word0[15:8] == 8'h00) && !word1[0] && !running;
      default:        func_ok = 1'b0;
    endcase
    start_ucode = (func_class == FN_START_UCODE) && func_ok;
  end
endmodule : function_decoder

// [src/port_command_control_block.sv]
/*
  Host-facing command front end: status/command register, block base registers,
  block fetch and function execution for codes 0, 1 and 3.
  Assumes an Avalon-MM master on the register side and an Avalon-MM read slave memory.
*/
`timescale 1ns/1ps
module port_command_control_block
  import port_cmd_pkg::*;
(
  input  wire logic                            ref_clk,
  input  wire logic                            rst_b,
  input  wire logic [4:0]                      avs_address,
  input  wire logic                            avs_read,
  input  wire logic                            avs_write,
  input  wire logic [port_cmd_pkg::BUS_W-1:0]  avs_writedata,
  input  wire logic [3:0]                      avs_byteenable,
  output logic [port_cmd_pkg::BUS_W-1:0]       avs_readdata,
  output logic                                 avs_waitrequest,
  output logic                                 mem_read,
  output logic [port_cmd_pkg::BASE_W-1:0]      mem_address,
  input  wire logic [port_cmd_pkg::REG_W-1:0]  mem_readdata,
  input  wire logic                            mem_waitrequest,
  output logic                                 irq,
  output logic                                 ucode_start,
  output logic [14:0]                          ucode_start_addr
);
  typedef enum logic [1:0] {CTL_IDLE, CTL_FETCH, CTL_EXEC} ctl_state_type;

  ctl_state_type       state;
  ctl_state_type       next_state;
  logic                served;
  logic                next_served;
  logic [BUS_W-1:0]    next_readdata;
  logic [CMD_W-1:0]    command;
  logic [CMD_W-1:0]    next_command;
  logic                int_enable;
  logic                next_int_enable;
  logic                done_flag;
  logic                next_done_flag;
  logic                error_flag;
  logic                next_error_flag;
  logic                running;
  logic                next_running;
  logic [15:0]         block_base_low_reg;
  logic [15:0]         next_base_low;
  logic [1:0]          base_high_bits;
  logic [1:0]          next_base_high;
  logic [BASE_W-1:0]   control_block_base;
  logic [BASE_W-1:0]   next_block_base;
  logic                next_ucode_start;
  logic [14:0]         next_ucode_addr;
  logic                fetch_start;
  logic                soft_reset;
  logic                fetch_done;
  logic [REG_W-1:0]    block_words [BLOCK_WORDS];
  func_class_type      func_class;
  logic                func_ok;
  logic                func_start_ucode;
  logic [REG_W-1:0]    port_cmd_status_reg;
  logic [REG_W-1:0]    block_base_high_reg;
  logic                wr_fire;
  logic                rd_pending;
  logic                status_write;
  logic                done_set;
  logic                error_set;
  logic [7:0]          flag_clear;

  block_fetcher #(
    .WORDS           (BLOCK_WORDS)
  ) u_fetcher (
    .ref_clk         (ref_clk),
    .rst_b           (rst_b),
    .abort           (soft_reset),
    .start           (fetch_start),
    .base            (control_block_base),
    .mem_read        (mem_read),
    .mem_address     (mem_address),
    .mem_readdata    (mem_readdata),
    .mem_waitrequest (mem_waitrequest),
    .words           (block_words),
    .done            (fetch_done)
  );

  function_decoder u_decoder (
    .word0           (block_words[0]),
    .word1           (block_words[1]),
    .running         (running),
    .func_class      (func_class),
    .func_ok         (func_ok),
    .start_ucode     (func_start_ucode)
  );

  // one wait state on every access gives a registered read path
  assign avs_waitrequest = (avs_read || avs_write) && !served;
  assign wr_fire         = avs_write && served;
  assign rd_pending      = avs_read && !served;
  assign irq             = int_enable && port_cmd_status_reg[SUMMARY_BIT];

  always_comb
  begin
    port_cmd_status_reg                = '0;
    port_cmd_status_reg[DONE_BIT]      = done_flag;
    port_cmd_status_reg[ERROR_BIT]     = error_flag;
    port_cmd_status_reg[SUMMARY_BIT]   = |port_cmd_status_reg[15:FLAG_LSB];
    port_cmd_status_reg[IE_BIT]        = int_enable;
    port_cmd_status_reg[CMD_W-1:0]     = command;
    block_base_high_reg                = {14'h0000, base_high_bits};
  end

  always_comb
  begin
    next_served      = (avs_read || avs_write) && !served;
    next_readdata    = avs_readdata;
    next_state       = state;
    next_command     = command;
    next_int_enable  = int_enable;
    next_running     = running;
    next_base_low    = block_base_low_reg;
    next_base_high   = base_high_bits;
    next_block_base  = control_block_base;
    next_ucode_start = 1'b0;
    next_ucode_addr  = ucode_start_addr;
    fetch_start      = 1'b0;
    soft_reset       = 1'b0;
    done_set         = 1'b0;
    error_set        = 1'b0;
    flag_clear       = 8'h00;
    status_write     = wr_fire && (avs_address == OFS_CMD_STATUS);
    if (rd_pending)
    begin
      case (avs_address)
        OFS_CMD_STATUS: next_readdata = {16'h0000, port_cmd_status_reg};
        OFS_BASE_LOW:   next_readdata = {16'h0000, block_base_low_reg};
        OFS_BASE_HIGH:  next_readdata = {16'h0000, block_base_high_reg};
        OFS_PORT_STATE: next_readdata = {16'h0000, running, ucode_start_addr};
        default:        next_readdata = '0;
      endcase
    end
    if (status_write && avs_byteenable[1])
      flag_clear = avs_writedata[15:8];
    if (status_write && avs_byteenable[0])
    begin
      if (avs_writedata[RESET_BIT])
        soft_reset = 1'b1;
      else if (avs_writedata[IE_BIT] != int_enable)
        next_int_enable = avs_writedata[IE_BIT];
      else if (state == CTL_IDLE)
      begin
        next_command = avs_writedata[CMD_W-1:0];
        case (avs_writedata[CMD_W-1:0])
          CMD_NULL:       ;
          CMD_LATCH_BASE:
          begin
            next_block_base = {base_high_bits, block_base_low_reg};
            done_set        = 1'b1;
          end
          CMD_FETCH:
          begin
            fetch_start = 1'b1;
            next_state  = CTL_FETCH;
          end
          default:        error_set = 1'b1;
        endcase
      end
    end
    if (wr_fire && avs_address == OFS_BASE_LOW)
    begin
      if (avs_byteenable[0])
        next_base_low[7:0] = {avs_writedata[7:1], 1'b0};
      if (avs_byteenable[1])
        next_base_low[15:8] = avs_writedata[15:8];
    end
    if (wr_fire && avs_address == OFS_BASE_HIGH && avs_byteenable[0])
      next_base_high = avs_writedata[1:0];
    case (state)
      CTL_IDLE:  ;
      CTL_FETCH: if (fetch_done) next_state = CTL_EXEC;
      CTL_EXEC:
      begin
        next_state = CTL_IDLE;
        done_set   = func_ok;
        error_set  = !func_ok;
        if (func_start_ucode)
        begin
          next_running     = 1'b1;
          next_ucode_start = 1'b1;
          next_ucode_addr  = block_words[1][15:1];
        end
      end
      default:   next_state = CTL_IDLE;
    endcase
    // a set in the same cycle as a clear wins
    next_done_flag  = done_set || (done_flag && !flag_clear[DONE_BIT-FLAG_LSB]);
    next_error_flag = error_set || (error_flag && !flag_clear[ERROR_BIT-FLAG_LSB]);
    if (soft_reset)
    begin
      next_state      = CTL_IDLE;
      next_command    = CMD_NULL;
      next_int_enable = 1'b0;
      next_running    = 1'b0;
      next_done_flag  = 1'b0;
      next_error_flag = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state              <= CTL_IDLE;
      served             <= 1'b0;
      avs_readdata       <= '0;
      command            <= CMD_NULL;
      int_enable         <= 1'b0;
      done_flag          <= 1'b0;
      error_flag         <= 1'b0;
      running            <= 1'b0;
      block_base_low_reg <= BASE_LOW_RESET;
      base_high_bits     <= BASE_HIGH_RESET;
      control_block_base <= '0;
      ucode_start        <= 1'b0;
      ucode_start_addr   <= '0;
    end
    else
    begin
      state              <= next_state;
      served             <= next_served;
      avs_readdata       <= next_readdata;
      command            <= next_command;
      int_enable         <= next_int_enable;
      done_flag          <= next_done_flag;
      error_flag         <= next_error_flag;
      running            <= next_running;
      block_base_low_reg <= next_base_low;
      base_high_bits     <= next_base_high;
      control_block_base <= next_block_base;
      ucode_start        <= next_ucode_start;
      ucode_start_addr   <= next_ucode_addr;
    end
  end

  sequence s_latch_write;
    status_write && avs_byteenable[0] && !avs_writedata[RESET_BIT]
      && (avs_writedata[IE_BIT] == int_enable) && (state == CTL_IDLE)
      && (avs_writedata[CMD_W-1:0] == CMD_LATCH_BASE);
  endsequence
  sequence s_fetch_write;
    status_write && avs_byteenable[0] && !avs_writedata[RESET_BIT]
      && (avs_writedata[IE_BIT] == int_enable) && (state == CTL_IDLE)
      && (avs_writedata[CMD_W-1:0] == CMD_FETCH);
  endsequence

  property p_high_zero;
    @(posedge ref_clk) disable iff (!rst_b)
    (avs_read && served && $past(avs_address) == OFS_BASE_HIGH) |-> avs_readdata[15:2] == '0;
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("base high upper bits not zero");

  property p_summary;
    @(posedge ref_clk) disable iff (!rst_b)
    $rose(done_flag || error_flag) |-> port_cmd_status_reg[SUMMARY_BIT];
  endproperty
  a_summary: assert property (p_summary) else $error("summary flag missing");

  property p_irq;
    @(posedge ref_clk) disable iff (!rst_b)
    irq |-> int_enable && (done_flag || error_flag);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without cause or enable");

  property p_w1c;
    @(posedge ref_clk) disable iff (!rst_b)
    (done_flag && !(status_write && avs_byteenable[1] && avs_writedata[DONE_BIT])
      && !soft_reset) |=> done_flag;
  endproperty
  a_w1c: assert property (p_w1c) else $error("done flag lost without a one");

  property p_interlock;
    @(posedge ref_clk) disable iff (!rst_b)
    (status_write && avs_byteenable[0] && !avs_writedata[RESET_BIT]
      && avs_writedata[IE_BIT] != int_enable) |=> $stable(command);
  endproperty
  a_interlock: assert property (p_interlock) else $error("command changed on enable toggle");

  property p_latch_done;
    @(posedge ref_clk) disable iff (!rst_b)
    s_latch_write |=> done_flag && control_block_base == {$past(base_high_bits),
      $past(block_base_low_reg)};
  endproperty
  a_latch_done: assert property (p_latch_done) else $error("latch command did not finish");

  property p_one_at_time;
    @(posedge ref_clk) disable iff (!rst_b)
    (state != CTL_IDLE && !soft_reset) |-> !fetch_start ##1 $stable(command);
  endproperty
  a_one_at_time: assert property (p_one_at_time) else $error("second command started");

  property p_fetch_addr;
    @(posedge ref_clk) disable iff (!rst_b)
    s_fetch_write |=> mem_read && mem_address == $past(control_block_base);
  endproperty
  a_fetch_addr: assert property (p_fetch_addr) else $error("fetch not at block base");

  property p_start_addr;
    @(posedge ref_clk) disable iff (!rst_b)
    ucode_start |-> running && ucode_start_addr == $past(block_words[1][15:1]);
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("wrong microcode start address");

  property p_func_err;
    @(posedge ref_clk) disable iff (!rst_b)
    (state == CTL_EXEC && func_class == FN_START_UCODE && block_words[0][15:8] != 8'h00)
      |=> error_flag && !ucode_start;
  endproperty
  a_func_err: assert property (p_func_err) else $error("start function error not raised");

  property p_low_even;
    @(posedge ref_clk) disable iff (!rst_b)
    !block_base_low_reg[0];
  endproperty
  a_low_even: assert property (p_low_even) else $error("block base low is odd");
endmodule : port_command_control_block

// [testbench/host_memory_model.sv]
/*
  Host memory holding one four-word control block, read over Avalon-MM.
  Assumes the bench supplies the block words and the base it sits at.
*/
`timescale 1ns/1ps
module host_memory_model
  import port_cmd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        slow,
  input  wire logic [17:0] base,
  input  wire logic [15:0] blk [4],
  input  wire logic        mem_read,
  input  wire logic [17:0] mem_address,
  output logic [15:0]      mem_readdata,
  output logic             mem_waitrequest
);
  logic [1:0]  wait_cnt;
  logic [15:0] last;
  logic [17:0] ofs;
  assign ofs = mem_address - base;
  assign mem_waitrequest = mem_read && (wait_cnt != 2'h0);
  // idle data is inverted so a late sample never matches by luck
  assign mem_readdata = (mem_read && !mem_waitrequest) ? blk[ofs[2:1]] : ~last;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wait_cnt <= 2'h0;
      last <= 16'h0000;
    end
    else if (!mem_read || !mem_waitrequest)
    begin
      wait_cnt <= slow ? 2'($urandom_range(3)) : 2'h0;
      if (mem_read)
        last <= mem_readdata;
    end
    else
      wait_cnt <= wait_cnt - 2'h1;
  end
endmodule : host_memory_model

// [testbench/tb.sv]
/*
  Self-checking bench of the port command block with a host memory model.
  Assumes one 125 MHz clock and active-low asynchronous reset.
*/
`timescale 1ns/1ps
module tb;
  import port_cmd_pkg::*;
  logic        ref_clk, rst_b, avs_read, avs_write, avs_waitrequest, slow, running;
  logic        mem_read, mem_waitrequest, irq, ucode_start;
  logic [4:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q, r;
  logic [17:0] mem_address, base;
  logic [15:0] mem_readdata, w0, w1, fl;
  logic [15:0] blk [4];
  logic [14:0] ucode_start_addr;
  int          errors, n_compared, n_words, n_starts, exp_starts;
  logic [15:0] w0s [10] = '{16'h0000, 16'h0003, 16'h0101, 16'h0001, 16'h0001, 16'h0001,
                            16'h0002, 16'h000d, 16'h0011, 16'h0015};

  port_command_control_block port_command_control_block_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_read(mem_read),
    .mem_address(mem_address), .mem_readdata(mem_readdata),
    .mem_waitrequest(mem_waitrequest), .irq(irq), .ucode_start(ucode_start),
    .ucode_start_addr(ucode_start_addr));
  host_memory_model host_memory_model_i (.ref_clk(ref_clk), .rst_b(rst_b), .slow(slow),
    .base(base), .blk(blk), .mem_read(mem_read), .mem_address(mem_address),
    .mem_readdata(mem_readdata), .mem_waitrequest(mem_waitrequest));

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task finish_test;
    if (errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // request held until the edge that sees waitrequest low, then released
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    int t;
    t = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && t < 50)
    begin
      t++;
      @(posedge ref_clk);
    end
    if (t >= 50)
    begin
      errors++;
      $display("BAD %0t bus request not answered", $time);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus

  task rd(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(q, exp);
  endtask : rd

  function automatic logic [15:0] flags_of(input logic [15:0] a, input logic [15:0] b,
                                           input logic run);
    if (a[7:0] == 8'h00 || a[7:0] == 8'h03)
      return 16'h2000;
    if (a[7:0] == 8'h01 && a[15:8] == 8'h00 && !b[0] && !run)
      return 16'h2000;
    return 16'h4000;
  endfunction : flags_of

  always @(posedge ref_clk)
  begin
    if (mem_read === 1'b1 && mem_waitrequest === 1'b0)
    begin
      chk(32'(mem_address), 32'(base + 18'(2 * n_words)));
      n_words++;
    end
    if (ucode_start === 1'b1)
      n_starts++;
  end

  initial
  begin
    #400000;
    errors++;
    finish_test();
  end

  initial
  begin
    void'($urandom(32'h4e5948e9));
    {rst_b, avs_read, avs_write, slow, running} = '0;
    {avs_address, avs_byteenable, avs_writedata, base} = '0;
    blk = '{default: 16'h0};
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rd(5'h00, 32'h0);
    rd(5'h0c, 32'h0);
    r = $urandom;
    bus(1'b1, 5'h08, r, 4'h3);
    bus(1'b1, 5'h0c, {16'h0, r[31:16]}, 4'h3);
    base = {r[17:16], r[15:1], 1'b0};
    rd(5'h08, {16'h0, r[15:1], 1'b0});
    rd(5'h0c, {30'h0, r[17:16]});
    bus(1'b1, 5'h04, 32'hffff, 4'hf);
    rd(5'h04, 32'h0);
    bus(1'b1, 5'h00, 32'h1, 4'h1);
    rd(5'h00, 32'h2081);
    chk(32'(irq), 32'h0);
    bus(1'b1, 5'h00, 32'h0, 4'h2);
    rd(5'h00, 32'h2081);
    bus(1'b1, 5'h00, 32'h2000, 4'h2);
    rd(5'h00, 32'h0001);
    bus(1'b1, 5'h00, 32'h0042, 4'h1);
    rd(5'h00, 32'h0041);
    // an unassigned command value ends at once with the error flag
    bus(1'b1, 5'h00, 32'h0045, 4'h1);
    rd(5'h00, 32'h40c5);
    chk(32'(irq), 32'h1);
    bus(1'b1, 5'h00, 32'h4000, 4'h2);
    rd(5'h00, 32'h0045);
    for (int i = 0; i < 16; i++)
    begin
      w0 = (i < 10) ? w0s[i] : 16'($urandom_range(16'h1ff));
      w1 = (16'($urandom) & 16'hfffe) | 16'(i == 3);
      blk[0] <= w0;
      blk[1] <= w1;
      blk[2] <= 16'($urandom);
      blk[3] <= 16'($urandom);
      slow <= 1'($urandom);
      fl = flags_of(w0, w1, running);
      n_words = 0;
      bus(1'b1, 5'h00, 32'h0042, 4'h1);
      bus(1'b1, 5'h00, 32'h0041, 4'h1);
      for (int t = 0; t < 40 && q[14:13] == 2'b00; t++)
        bus(1'b0, 5'h00, 32'h0, 4'hf);
      chk(q, {16'h0, fl | 16'h00c2});
      chk(32'(n_words), 32'd4);
      chk(32'(irq), 32'h1);
      if (w0[7:0] == 8'h01 && fl == 16'h2000)
      begin
        running = 1'b1;
        exp_starts++;
        chk(32'(ucode_start_addr), 32'(w1[15:1]));
      end
      chk(32'(n_starts), 32'(exp_starts));
      bus(1'b1, 5'h00, 32'h6000, 4'h2);
      rd(5'h00, 32'h0042);
      chk(32'(irq), 32'h0);
    end
    bus(1'b1, 5'h00, 32'h0020, 4'h1);
    rd(5'h00, 32'h0);
    bus(1'b0, 5'h10, 32'h0, 4'hf);
    chk(32'(q[15]), 32'h0);
    // a port reset needs a quiet 100 us before the next command
    repeat (12500) @(posedge ref_clk);
    finish_test();
  end
endmodule : tb
